// *** acm_afe_regs.sv ***
// module: configuration and error mask registers behind an AXI4-Lite slave
//
// Notes on behaviour
// - configuration register at index 0x5, sixteen bits, resets to zero.
// - bit 15 selects four-wire (0) or two/three-wire (1) RTD wiring.
// - bits 14:12 and 11:9 set compensation and excitation current.
// - bit 8 picks internal (0) or external (1) RTD reference resistor.
// - bits 7:4 set channel gain, 0.2 up to 24 in sixteen steps.
// - error mask register at index 0x6, sixteen bits, resets to zero.
// - a set mask bit removes its fault from the summary bit.
// - the fault alert pin shows the same masked summary.
// - mask bits 11..6, 2 and 1 each belong to one fault.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module acm_afe_regs
   import acm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // axi4-lite write address
   input wire logic [ACM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ACM_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // raw fault conditions, same bit layout as the mask register
   input wire logic [15:0] fault_conditions_i,
   // decoded front-end settings
   output logic rtd_wiring_select_o,
   output logic rtd_reference_resistor_select_o,
   output logic [3:0] channel_gain_code_o,
   output logic [9:0] compensation_current_ua_o,
   output logic [9:0] excitation_current_ua_o,
   output logic [14:0] channel_gain_milli_o,
   // fault alert pin and interrupt
   output logic fault_alert_o,
   output logic irq_o
);

   acm_cfg_if cfg_if ();

   // write channel state
   acm_wr_st_t wr_st_q;
   logic aw_held_q;
   logic w_held_q;
   logic [5:0] wr_idx_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   logic wr_go;
   logic [15:0] wr_lanes;

   // read channel state
   acm_rd_st_t rd_st_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic ar_fire;

   // register contents
   logic [15:0] cfg_q;
   logic [15:0] mask_q;
   logic [15:0] irq_stat_q;
   logic [15:0] irq_en_q;
   logic [15:0] irq_set;
   logic [15:0] irq_clr;

   // merge a write through byte lanes, then drop reserved bits
   function automatic logic [15:0] acm_merge(input logic [15:0] old_v,
         input logic [15:0] new_v, input logic [15:0] lanes,
         input logic [15:0] wmask);
      acm_merge = ((old_v & ~lanes) | (new_v & lanes)) & wmask;
   endfunction : acm_merge

   // true for the indices that this slave answers
   function automatic logic acm_mapped(input logic [5:0] idx);
      acm_mapped = (idx == ACM_IDX_TOP_STATUS) || (idx == ACM_IDX_CFG) ||
         (idx == ACM_IDX_MASK) || (idx == ACM_IDX_IRQ_STAT) ||
         (idx == ACM_IDX_IRQ_EN);
   endfunction : acm_mapped

   // handshake outputs straight from the channel state
   assign s_axi_awready = (wr_st_q == ACM_WS_COLLECT) && !aw_held_q;
   assign s_axi_wready = (wr_st_q == ACM_WS_COLLECT) && !w_held_q;
   assign s_axi_bvalid = (wr_st_q == ACM_WS_RESP);
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = (rd_st_q == ACM_RS_IDLE);
   assign s_axi_rvalid = (rd_st_q == ACM_RS_DATA);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // commit only once both halves are held, so arrival order never matters
   assign wr_go = (wr_st_q == ACM_WS_COLLECT) && aw_held_q && w_held_q;
   assign wr_lanes = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign ar_fire = s_axi_arvalid && s_axi_arready;

   // write address and data capture, in either order
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         wr_idx_q <= 6'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            wr_idx_q <= s_axi_awaddr[ACM_IDX_LSB +: 6];
         end else if (wr_go) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // write response: unmapped index answers slverr
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_st_q <= ACM_WS_COLLECT;
         bresp_q <= ACM_RESP_OKAY;
      end else begin
         case (wr_st_q)
            ACM_WS_COLLECT: begin
               if (wr_go) begin
                  wr_st_q <= ACM_WS_RESP;
                  bresp_q <= acm_mapped(wr_idx_q) ? ACM_RESP_OKAY :
                     ACM_RESP_SLVERR;
               end
            end
            ACM_WS_RESP: begin
               if (s_axi_bready) begin
                  wr_st_q <= ACM_WS_COLLECT;
               end
            end
            default: begin
               wr_st_q <= ACM_WS_COLLECT;
            end
         endcase
      end
   end

   // read: data registered, reads have no side effects
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_st_q <= ACM_RS_IDLE;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ACM_RESP_OKAY;
      end else begin
         case (rd_st_q)
            ACM_RS_IDLE: begin
               if (ar_fire) begin
                  rd_st_q <= ACM_RS_DATA;
                  rresp_q <= ACM_RESP_OKAY;
                  case (s_axi_araddr[ACM_IDX_LSB +: 6])
                     ACM_IDX_TOP_STATUS: begin
                        rdata_q <= 32'h0000_0000;
                        rdata_q[ACM_SUMMARY_BIT] <= cfg_if.summary;
                     end
                     ACM_IDX_CFG: rdata_q <= {16'h0000, cfg_q};
                     ACM_IDX_MASK: rdata_q <= {16'h0000, mask_q};
                     ACM_IDX_IRQ_STAT: rdata_q <= {16'h0000, irq_stat_q};
                     ACM_IDX_IRQ_EN: rdata_q <= {16'h0000, irq_en_q};
                     default: begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= ACM_RESP_SLVERR;
                     end
                  endcase
               end
            end
            ACM_RS_DATA: begin
               if (s_axi_rready) begin
                  rd_st_q <= ACM_RS_IDLE;
               end
            end
            default: begin
               rd_st_q <= ACM_RS_IDLE;
            end
         endcase
      end
   end

   // gain_and_rtd_config; reserved low nibble never stores
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_q <= ACM_CFG_RESET;
      end else if (wr_go && wr_idx_q == ACM_IDX_CFG) begin
         cfg_q <= acm_merge(cfg_q, wdata_q[15:0], wr_lanes,
            ACM_CFG_WMASK);
      end
   end

   // error_report_mask; zero after reset so every fault reports
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_q <= ACM_MASK_RESET;
      end else if (wr_go && wr_idx_q == ACM_IDX_MASK) begin
         mask_q <= acm_merge(mask_q, wdata_q[15:0], wr_lanes,
            ACM_MASK_WMASK);
      end
   end

   // interrupt enables share the mask layout
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_en_q <= ACM_IRQ_EN_RESET;
      end else if (wr_go && wr_idx_q == ACM_IDX_IRQ_EN) begin
         irq_en_q <= acm_merge(irq_en_q, wdata_q[15:0], wr_lanes,
            ACM_MASK_WMASK);
      end
   end

   // sticky fault events; a new fault beats a same-cycle clear
   assign irq_set = fault_conditions_i & ~mask_q & ACM_MASK_WMASK;
   assign irq_clr = (wr_go && wr_idx_q == ACM_IDX_IRQ_STAT) ?
      (wdata_q[15:0] & wr_lanes) : 16'h0000;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat_q <= ACM_IRQ_STAT_RESET;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      end
   end

   // level interrupt, registered to keep the pin glitch free
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_q & irq_en_q);
      end
   end

   // hand the register contents to the leaf modules
   assign cfg_if.cfg = cfg_q;
   assign cfg_if.mask = mask_q;
   assign cfg_if.fault = fault_conditions_i;

   acm_cfg_decode u_decode (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .cfg_if(cfg_if.decode)
   );

   acm_fault_gate u_gate (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .gate_if(cfg_if.gate)
   );

   // decoded outputs; the leaves already register them
   assign rtd_wiring_select_o = cfg_if.wiring;
   assign rtd_reference_resistor_select_o = cfg_if.res_sel;
   assign channel_gain_code_o = cfg_if.gain_code;
   assign compensation_current_ua_o = cfg_if.comp_ua;
   assign excitation_current_ua_o = cfg_if.exc_ua;
   assign channel_gain_milli_o = cfg_if.gain_milli;
   // alert pin shares the summary flop, so pin and bit never differ
   assign fault_alert_o = cfg_if.summary;

   // calibration reads rely on the stored gain code staying put;
   // the register holds what was written until the next write

   // first cycle out of reset sees both registers cleared
   a_cfg_reset_zero: assert property (@(posedge sys_clk_i)
      $rose(rst_n_i) |-> (cfg_q == 16'h0000))
      else $error("configuration not zero after reset");

   a_mask_reset_zero: assert property (@(posedge sys_clk_i)
      $rose(rst_n_i) |-> (mask_q == 16'h0000))
      else $error("mask not zero after reset");

   a_cfg_write_land: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      (wr_go && wr_idx_q == ACM_IDX_CFG && wstrb_q[1:0] == 2'h3)
      |=> (cfg_q == ($past(wdata_q[15:0]) & 16'hfff0)))
      else $error("full configuration write not stored");

   a_wiring_follow: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      ##1 (rtd_wiring_select_o == $past(cfg_q[15])))
      else $error("wiring select does not follow bit 15");

   a_exc_current_map: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      ($past(cfg_q[11:9]) == 3'h7 |-> excitation_current_ua_o == 10'd1000)
      and ($past(cfg_q[11:9]) == 3'h0 |-> excitation_current_ua_o == 10'd0))
      else $error("excitation current decode wrong");

   a_comp_current_map: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      ($past(cfg_q[14:12]) inside {3'h3, 3'h4}) |->
      (compensation_current_ua_o == 10'd500))
      else $error("compensation current decode wrong");

   a_res_select_follow: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      $rose(cfg_q[8]) |=> rtd_reference_resistor_select_o)
      else $error("resistor select does not follow bit 8");

   a_gain_ends_map: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      ($past(cfg_q[7:4]) == 4'hf |-> channel_gain_milli_o == 15'd24000)
      and ($past(cfg_q[7:4]) == 4'h0 |-> channel_gain_milli_o == 15'd200))
      else $error("gain decode wrong at code ends");

   a_summary_gating: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      ##1 (cfg_if.summary ==
      $past(|(fault_conditions_i & ~mask_q & 16'h0fc6))))
      else $error("summary fault bit gating wrong");

   a_alert_matches: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      (mask_q == 16'h0fc6) [*2] |-> !fault_alert_o)
      else $error("alert pin raised with every fault masked");

   a_reserved_zero: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      ((cfg_q & 16'h000f) == 16'h0000) && ((mask_q & 16'hf039) == 16'h0000))
      else $error("reserved bit holds a one");

   a_mask_bit_owner: assert property (@(posedge sys_clk_i)
      disable iff (!rst_n_i)
      (mask_q[11] && $past(mask_q[11]) && fault_conditions_i == 16'h0800)
      |=> !cfg_if.summary)
      else $error("masked negative undervoltage reached summary");

endmodule : acm_afe_regs
`default_nettype wire

// *** acm_pkg.sv ***
// package: offsets, field layout, reset values and decode functions
package acm_pkg;

   // bus geometry: a register index sits at byte address index*4
   localparam int unsigned ACM_ADDR_W = 8;
   localparam int unsigned ACM_IDX_LSB = 2;
   localparam logic [5:0] ACM_IDX_TOP_STATUS = 6'h00;
   localparam logic [5:0] ACM_IDX_CFG = 6'h05;
   localparam logic [5:0] ACM_IDX_MASK = 6'h06;
   localparam logic [5:0] ACM_IDX_IRQ_STAT = 6'h10;
   localparam logic [5:0] ACM_IDX_IRQ_EN = 6'h11;

   // reset values
   localparam logic [15:0] ACM_CFG_RESET = 16'h0000;
   localparam logic [15:0] ACM_MASK_RESET = 16'h0000;
   localparam logic [15:0] ACM_IRQ_STAT_RESET = 16'h0000;
   localparam logic [15:0] ACM_IRQ_EN_RESET = 16'h0000;

   // writable bits; everything else reads zero
   localparam logic [15:0] ACM_CFG_WMASK = 16'hfff0;
   localparam logic [15:0] ACM_MASK_WMASK = 16'h0fc6;

   // gain_and_rtd_config fields
   localparam int unsigned ACM_WIRING_BIT = 15;
   localparam int unsigned ACM_COMP_LSB = 12;
   localparam int unsigned ACM_EXC_LSB = 9;
   localparam int unsigned ACM_RES_BIT = 8;
   localparam int unsigned ACM_GAIN_LSB = 4;

   // top_status_register: summary_fault_bit position
   localparam int unsigned ACM_SUMMARY_BIT = 0;

   // bus responses
   localparam logic [1:0] ACM_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACM_RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      ACM_WS_COLLECT = 1'b0,
      ACM_WS_RESP = 1'b1
   } acm_wr_st_t;

   typedef enum logic [0:0] {
      ACM_RS_IDLE = 1'b0,
      ACM_RS_DATA = 1'b1
   } acm_rd_st_t;

   // current code to microamps, shared by both current fields
   function automatic logic [9:0] acm_current_ua(input logic [2:0] code);
      case (code)
         3'h0: acm_current_ua = 10'd0;
         3'h1: acm_current_ua = 10'd100;
         3'h2: acm_current_ua = 10'd400;
         3'h3: acm_current_ua = 10'd500;
         3'h4: acm_current_ua = 10'd500;
         3'h5: acm_current_ua = 10'd600;
         3'h6: acm_current_ua = 10'd900;
         default: acm_current_ua = 10'd1000;
      endcase
   endfunction : acm_current_ua

   // gain code to gain times 1000
   function automatic logic [14:0] acm_gain_milli(input logic [3:0] code);
      case (code)
         4'h0: acm_gain_milli = 15'd200;
         4'h1: acm_gain_milli = 15'd250;
         4'h2: acm_gain_milli = 15'd300;
         4'h3: acm_gain_milli = 15'd375;
         4'h4: acm_gain_milli = 15'd500;
         4'h5: acm_gain_milli = 15'd750;
         4'h6: acm_gain_milli = 15'd1000;
         4'h7: acm_gain_milli = 15'd1500;
         4'h8: acm_gain_milli = 15'd2000;
         4'h9: acm_gain_milli = 15'd3000;
         4'ha: acm_gain_milli = 15'd4000;
         4'hb: acm_gain_milli = 15'd6000;
         4'hc: acm_gain_milli = 15'd8000;
         4'hd: acm_gain_milli = 15'd12000;
         4'he: acm_gain_milli = 15'd16000;
         default: acm_gain_milli = 15'd24000;
      endcase
   endfunction : acm_gain_milli

endpackage : acm_pkg

// *** acm_cfg_if.sv ***
// interface: register contents out to the decoder and the fault gate
`timescale 1ns/1ns
`default_nettype none
interface acm_cfg_if;
   logic [15:0] cfg;
   logic [15:0] mask;
   logic [15:0] fault;
   logic summary;
   logic wiring;
   logic res_sel;
   logic [3:0] gain_code;
   logic [9:0] comp_ua;
   logic [9:0] exc_ua;
   logic [14:0] gain_milli;

   modport regs (output cfg, mask, fault,
      input summary, wiring, res_sel, gain_code, comp_ua, exc_ua, gain_milli);
   modport gate (input mask, fault, output summary);
   modport decode (input cfg,
      output wiring, res_sel, gain_code, comp_ua, exc_ua, gain_milli);
endinterface : acm_cfg_if
`default_nettype wire

// *** acm_cfg_decode.sv ***
// module: registered decode of the front-end configuration word
`timescale 1ns/1ns
`default_nettype none
module acm_cfg_decode
   import acm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // configuration in, decoded settings out
   acm_cfg_if.decode cfg_if
);

   // settings follow the register one clock later
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_if.wiring <= 1'b0;
         cfg_if.res_sel <= 1'b0;
         cfg_if.gain_code <= 4'h0;
         cfg_if.comp_ua <= 10'd0;
         cfg_if.exc_ua <= 10'd0;
         cfg_if.gain_milli <= 15'd200;
      end else begin
         cfg_if.wiring <= cfg_if.cfg[ACM_WIRING_BIT];
         cfg_if.res_sel <= cfg_if.cfg[ACM_RES_BIT];
         cfg_if.gain_code <= cfg_if.cfg[ACM_GAIN_LSB +: 4];
         cfg_if.comp_ua <= acm_current_ua(cfg_if.cfg[ACM_COMP_LSB +: 3]);
         cfg_if.exc_ua <= acm_current_ua(cfg_if.cfg[ACM_EXC_LSB +: 3]);
         cfg_if.gain_milli <= acm_gain_milli(cfg_if.cfg[ACM_GAIN_LSB +: 4]);
      end
   end

endmodule : acm_cfg_decode
`default_nettype wire

// *** acm_fault_gate.sv ***
// module: masked summary of the front-end fault conditions
`timescale 1ns/1ns
`default_nettype none
module acm_fault_gate
   import acm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // mask and faults in, summary out
   acm_cfg_if.gate gate_if
);

   // one flop for the summary, so bit and pin can never disagree
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_if.summary <= 1'b0;
      end else begin
         gate_if.summary <= |(gate_if.fault & ~gate_if.mask & ACM_MASK_WMASK);
      end
   end

endmodule : acm_fault_gate
`default_nettype wire

// *** afe_config_error_mask_tb.sv ***
// testbench: register access, decode, fault gating and interrupt checks
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module afe_config_error_mask_tb;
   import acm_pkg::*;
   localparam logic [7:0] A_ST = {ACM_IDX_TOP_STATUS, 2'b00};
   localparam logic [7:0] A_CFG = {ACM_IDX_CFG, 2'b00};
   localparam logic [7:0] A_MSK = {ACM_IDX_MASK, 2'b00};
   localparam logic [7:0] A_IST = {ACM_IDX_IRQ_STAT, 2'b00};
   localparam logic [7:0] A_IEN = {ACM_IDX_IRQ_EN, 2'b00};
   localparam logic [7:0] A_BAD = 8'h04;
   localparam logic [1:0] OK = ACM_RESP_OKAY;
   // bus, fault and decoded-output signals
   logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb, gain_code;
   logic [1:0] bresp, rresp;
   logic [15:0] faults, d, m, f;
   logic wiring, res_sel, alert, irq;
   logic [9:0] comp_ua, exc_ua;
   logic [14:0] gain_milli;
   int bad_count, cmp_count, cycles, b;
   integer seed;
   int fbits[8] = '{11, 10, 9, 8, 7, 6, 2, 1};

   acm_afe_regs u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .fault_conditions_i(faults),
      .rtd_wiring_select_o(wiring),
      .rtd_reference_resistor_select_o(res_sel),
      .channel_gain_code_o(gain_code), .compensation_current_ua_o(comp_ua),
      .excitation_current_ua_o(exc_ua), .channel_gain_milli_o(gain_milli),
      .fault_alert_o(alert), .irq_o(irq));

   // expected current in microamps for a 3-bit code
   function automatic logic [9:0] exp_ua(input logic [2:0] c);
      int t[8] = '{0, 100, 400, 500, 500, 600, 900, 1000};
      return 10'(t[c]);
   endfunction : exp_ua

   // expected gain times 1000 for a 4-bit code
   function automatic logic [14:0] exp_gain(input logic [3:0] c);
      int t[16] = '{200, 250, 300, 375, 500, 750, 1000, 1500, 2000, 3000,
         4000, 6000, 8000, 12000, 16000, 24000};
      return 15'(t[c]);
   endfunction : exp_gain

   // one write; address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [15:0] dv,
         input logic [1:0] er);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= {~dv, dv}; // upper half must be ignored
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge sys_clk);
         if (!aw && awready) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge sys_clk); while (!bvalid);
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask : wr

   // one read; rready held until rvalid is sampled
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge sys_clk); while (!rvalid);
      v = rdata;
      rready <= 1'b0;
      `CHK(rresp, er)
   endtask : rd

   // outputs trail their cause by up to three edges
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic fset(input logic [15:0] fv);
      @(posedge sys_clk);
      faults <= fv;
      settle();
   endtask : fset

   task automatic tally_and_finish();
      $display("mismatches=%0d compares=%0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // hang guard, well above the expected thousand or so cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   initial begin
      seed = 32'hccaa;
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, faults} = '0;
      wstrb = 4'hf;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      // reset state
      rd(A_CFG, OK);
      `CHK(v, 32'h0)
      rd(A_MSK, OK);
      `CHK(v, 32'h0)
      `CHK(gain_milli, 15'd200)
      // every current and gain code, random other bits
      for (int i = 0; i < 16; i++) begin
         d = 16'($random(seed));
         d[15] = i[0];
         d[8] = i[1];
         d[14:12] = i[2:0];
         d[11:9] = 3'(7 - i);
         d[7:4] = i[3:0];
         wr(A_CFG, d, OK);
         settle();
         rd(A_CFG, OK);
         `CHK(v, {16'h0, d & 16'hfff0})
         `CHK(wiring, d[15])
         `CHK(comp_ua, exp_ua(d[14:12]))
         `CHK(exc_ua, exp_ua(d[11:9]))
         `CHK(res_sel, d[8])
         `CHK(gain_code, d[7:4])
         `CHK(gain_milli, exp_gain(d[7:4]))
      end
      // byte lanes: only the upper lane lands, low byte keeps its value
      wstrb <= 4'h2;
      wr(A_CFG, 16'h5a5a, OK);
      wstrb <= 4'hf;
      rd(A_CFG, OK);
      `CHK(v, {16'h0, 8'h5a, d[7:4], 4'h0})
      // each fault alone: reported, masked by its own bit only
      for (int k = 0; k < 8; k++) begin
         b = fbits[k];
         wr(A_MSK, 16'h0, OK);
         fset(16'h1 << b);
         `CHK(alert, 1'b1)
         rd(A_ST, OK);
         `CHK(v, 32'h1)
         wr(A_MSK, 16'h1 << b, OK);
         settle();
         `CHK(alert, 1'b0)
         rd(A_ST, OK);
         `CHK(v, 32'h0)
         wr(A_MSK, ~(16'h1 << b), OK);
         settle();
         `CHK(alert, 1'b1)
      end
      // corner: every fault present, every fault masked
      wr(A_MSK, 16'hffff, OK);
      fset(16'hffff);
      `CHK(alert, 1'b0)
      rd(A_MSK, OK);
      `CHK(v, 32'h0000_0fc6)
      // random masks and faults, reserved bits included
      for (int k = 0; k < 24; k++) begin
         m = 16'($random(seed));
         f = 16'($random(seed));
         wr(A_MSK, m, OK);
         fset(f);
         rd(A_MSK, OK);
         `CHK(v, {16'h0, m & 16'h0fc6})
         `CHK(alert, |(f & ~m & 16'h0fc6))
         rd(A_ST, OK);
         `CHK(v[0], |(f & ~m & 16'h0fc6))
         `CHK(irq, 1'b0)
      end
      // interrupt: raise, hold, clear, mask, disable
      fset(16'h0);
      wr(A_MSK, 16'h0, OK);
      wr(A_IST, 16'hffff, OK);
      wr(A_IEN, 16'h0002, OK);
      fset(16'h0002);
      fset(16'h0);
      `CHK(irq, 1'b1)
      rd(A_IST, OK);
      `CHK(v, 32'h2)
      wr(A_IST, 16'h0002, OK);
      settle();
      `CHK(irq, 1'b0)
      wr(A_MSK, 16'h0002, OK);
      fset(16'h0002);
      `CHK(irq, 1'b0)
      wr(A_MSK, 16'h0, OK);
      settle();
      `CHK(irq, 1'b1)
      wr(A_IEN, 16'h0, OK);
      settle();
      `CHK(irq, 1'b0)
      // unmapped and read-only places
      wr(A_BAD, 16'hffff, ACM_RESP_SLVERR);
      rd(A_BAD, ACM_RESP_SLVERR);
      `CHK(v, 32'h0)
      wr(A_ST, 16'h0000, OK);
      rd(A_ST, OK);
      `CHK(v, 32'h1)
      tally_and_finish();
   end
endmodule : afe_config_error_mask_tb
`default_nettype wire
